// ### rtl/serial_bus_ctrl.sv
// Design decisions made here: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
module serial_bus_ctrl
(
   input wire logic i_core_clk, // core clock
   input wire logic i_resetn, // sync reset, active low
   input wire logic i_wb_cyc, // bus cycle
   input wire logic i_wb_stb, // bus strobe
   input wire logic i_wb_we, // write enable
   input wire logic [7:0] i_wb_adr, // byte address
   input wire logic [3:0] i_wb_sel, // byte selects
   input wire logic [31:0] i_wb_dat, // write data
   output logic [31:0] o_wb_dat, // read data
   output logic o_wb_ack, // bus acknowledge
   input wire serial_bus_pkg::pins_s i_pins, // pin levels
   output serial_bus_pkg::pins_s o_pins, // pin out data, always low
   output serial_bus_pkg::pins_s o_pins_oe, // pin pull-low enables
   output logic o_port_mode, // pins free as general ports
   output logic o_irq // interrupt, level
);
   // =====================================================
   // divisor table lookup
   function automatic logic [8:0] divisor(input logic ext, input logic [2:0] sel);
      divisor = serial_bus_pkg::DIV_TABLE[{ext, sel}];
   endfunction

   // =====================================================
   // register file and bus slave
   serial_bus_pkg::ctrl_s ctrl_reg, ctrl_next;
   logic ext_reg, ext_next;
   logic [1:0] ev_reg, ev_next;
   logic [1:0] mask_reg, mask_next;
   logic ack_reg, ack_next;
   logic [31:0] rdat_reg, rdat_next;
   logic wr_commit;
   logic start_xfer;
   logic [1:0] ev_set;
   logic busy;
   logic [7:0] rx_reg, rx_next;
   logic ackin_reg, ackin_next;
   logic scl_f_reg, sda_f_reg;

   // write lands on the edge where the master sees ack
   assign wr_commit = i_wb_cyc & i_wb_stb & i_wb_we & ack_reg & i_wb_sel[0];
   assign start_xfer = wr_commit & (i_wb_adr == serial_bus_pkg::OFS_DATA)
      & ctrl_reg.iface_enable & ~busy;

   // next values of the register file
   always_comb
   begin
      ctrl_next = ctrl_reg;
      ext_next = ext_reg;
      mask_next = mask_reg;
      ev_next = ev_reg;
      rdat_next = rdat_reg;
      ack_next = i_wb_cyc & i_wb_stb & ~ack_reg;
      if (wr_commit)
      begin
         unique case (i_wb_adr)
            serial_bus_pkg::OFS_CTRL: ctrl_next = i_wb_dat[7:0];
            serial_bus_pkg::OFS_TIMER_CTRL: ext_next = i_wb_dat[serial_bus_pkg::PRESCALE_EXT_POS];
            serial_bus_pkg::OFS_IRQ_STAT: ev_next = ev_reg & ~i_wb_dat[1:0];
            serial_bus_pkg::OFS_IRQ_MASK: mask_next = i_wb_dat[1:0];
            default: ;
         endcase
      end
      // set beats clear in the same cycle
      ev_next = ev_next | ev_set;
      if (ack_next)
      begin
         rdat_next = 32'h0000_0000;
         unique case (i_wb_adr)
            serial_bus_pkg::OFS_CTRL: rdat_next[7:0] = ctrl_reg;
            serial_bus_pkg::OFS_TIMER_CTRL:
               rdat_next[serial_bus_pkg::PRESCALE_EXT_POS] = ext_reg;
            serial_bus_pkg::OFS_DATA: rdat_next[7:0] = rx_reg;
            serial_bus_pkg::OFS_STATUS: rdat_next[3:0] = {sda_f_reg, scl_f_reg, ackin_reg, busy};
            serial_bus_pkg::OFS_IRQ_STAT: rdat_next[1:0] = ev_reg;
            serial_bus_pkg::OFS_IRQ_MASK: rdat_next[1:0] = mask_reg;
            default: ;
         endcase
      end
   end

   // register the file
   always_ff @(posedge i_core_clk)
   begin
      if (!i_resetn)
      begin
         ctrl_reg <= serial_bus_pkg::CTRL_RESET;
         ext_reg <= 1'b0;
         ev_reg <= serial_bus_pkg::EV_RESET;
         mask_reg <= serial_bus_pkg::EV_RESET;
         ack_reg <= 1'b0;
         rdat_reg <= 32'h0000_0000;
      end
      else
      begin
         ctrl_reg <= ctrl_next;
         ext_reg <= ext_next;
         ev_reg <= ev_next;
         mask_reg <= mask_next;
         ack_reg <= ack_next;
         rdat_reg <= rdat_next;
      end
   end

   assign o_wb_ack = ack_reg;
   assign o_wb_dat = rdat_reg;
   assign o_irq = ctrl_reg.iface_irq_enable & |(ev_reg & mask_reg);

   // =====================================================
   // pin synchronisers, three stages with agreement filter
   logic [2:0] scl_s_reg, scl_s_next, sda_s_reg, sda_s_next;
   logic scl_f_next, sda_f_next;

   // a level counts once stages two and three agree
   always_comb
   begin
      scl_s_next = {scl_s_reg[1:0], i_pins.scl};
      sda_s_next = {sda_s_reg[1:0], i_pins.sda};
      scl_f_next = (scl_s_reg[1] == scl_s_reg[2]) ? scl_s_reg[2] : scl_f_reg;
      sda_f_next = (sda_s_reg[1] == sda_s_reg[2]) ? sda_s_reg[2] : sda_f_reg;
   end

   // idle bus is high, so reset to one
   always_ff @(posedge i_core_clk)
   begin
      if (!i_resetn)
      begin
         scl_s_reg <= 3'h7;
         sda_s_reg <= 3'h7;
         scl_f_reg <= 1'b1;
         sda_f_reg <= 1'b1;
      end
      else
      begin
         scl_s_reg <= scl_s_next;
         sda_s_reg <= sda_s_next;
         scl_f_reg <= scl_f_next;
         sda_f_reg <= sda_f_next;
      end
   end

   // =====================================================
   // byte transfer engine
   serial_bus_pkg::xfer_state_e st_reg, st_next;
   logic [7:0] cnt_reg, cnt_next;
   logic [3:0] bit_reg, bit_next;
   logic [7:0] sh_reg, sh_next;
   logic [8:0] div_reg, div_next;
   logic scl_oe_reg, scl_oe_next, sda_oe_reg, sda_oe_next;
   logic scl_prev_reg;
   logic [3:0] nbits;
   logic phase_end, rise_seen, fall_seen, last_bit, sample;

   assign busy = (st_reg != serial_bus_pkg::ST_IDLE);
   // acknowledge bit present only in ack format
   assign nbits = ctrl_reg.serial_format ? serial_bus_pkg::BITS_NO_ACK
      : serial_bus_pkg::BITS_WITH_ACK;
   assign last_bit = (bit_reg == nbits - 4'h1);
   assign rise_seen = scl_f_reg & ~scl_prev_reg;
   assign fall_seen = ~scl_f_reg & scl_prev_reg;
   // master counts halves, slave follows the line
   assign phase_end = ctrl_reg.master_select ? (cnt_reg == 8'h00)
      : ((st_reg == serial_bus_pkg::ST_LOW) ? rise_seen : fall_seen);
   assign sample = sda_f_reg;

   // next state of the engine
   always_comb
   begin
      st_next = st_reg;
      cnt_next = cnt_reg;
      bit_next = bit_reg;
      sh_next = sh_reg;
      div_next = div_reg;
      scl_oe_next = scl_oe_reg;
      sda_oe_next = sda_oe_reg;
      rx_next = rx_reg;
      ackin_next = ackin_reg;
      ev_set = 2'h0;
      if (cnt_reg != 8'h00)
      begin
         cnt_next = cnt_reg - 8'h01;
      end
      unique case (st_reg)
         serial_bus_pkg::ST_IDLE:
         begin
            scl_oe_next = 1'b0;
            sda_oe_next = 1'b0;
            if (start_xfer)
            begin
               div_next = divisor(ext_reg, ctrl_reg.clk_sel);
               sh_next = i_wb_dat[7:0];
               bit_next = 4'h0;
               st_next = serial_bus_pkg::ST_LOW;
               cnt_next = div_next[8:1] - 8'h01;
            end
         end
         serial_bus_pkg::ST_LOW:
         begin
            scl_oe_next = ctrl_reg.master_select;
            if (bit_reg == serial_bus_pkg::ACK_BIT_IDX)
            begin
               sda_oe_next = ~ctrl_reg.transmit_select;
            end
            else
            begin
               sda_oe_next = ctrl_reg.transmit_select & ~sh_reg[7];
            end
            if (phase_end)
            begin
               st_next = serial_bus_pkg::ST_HIGH;
               cnt_next = div_reg[8:1] - 8'h01;
            end
         end
         serial_bus_pkg::ST_HIGH:
         begin
            scl_oe_next = 1'b0;
            if (phase_end)
            begin
               if (bit_reg == serial_bus_pkg::ACK_BIT_IDX)
               begin
                  ackin_next = sample;
                  ev_set[serial_bus_pkg::EV_NACK_POS] = ctrl_reg.transmit_select & sample;
               end
               else
               begin
                  sh_next = {sh_reg[6:0], sample};
               end
               if (bit_reg == serial_bus_pkg::LAST_DATA_IDX)
               begin
                  rx_next = {sh_reg[6:0], sample};
               end
               if (last_bit)
               begin
                  st_next = serial_bus_pkg::ST_IDLE;
                  sda_oe_next = 1'b0;
                  ev_set[serial_bus_pkg::EV_DONE_POS] = 1'b1;
               end
               else
               begin
                  st_next = serial_bus_pkg::ST_LOW;
                  bit_next = bit_reg + 4'h1;
                  cnt_next = div_reg[8:1] - 8'h01;
               end
            end
         end
      endcase
      // disabling releases both pins at once
      if (!ctrl_reg.iface_enable)
      begin
         st_next = serial_bus_pkg::ST_IDLE;
         scl_oe_next = 1'b0;
         sda_oe_next = 1'b0;
      end
   end

   // register the engine
   always_ff @(posedge i_core_clk)
   begin
      if (!i_resetn)
      begin
         st_reg <= serial_bus_pkg::ST_IDLE;
         cnt_reg <= 8'h00;
         bit_reg <= 4'h0;
         sh_reg <= serial_bus_pkg::BYTE_RESET;
         div_reg <= 9'h000;
         scl_oe_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
         rx_reg <= serial_bus_pkg::BYTE_RESET;
         ackin_reg <= 1'b0;
         scl_prev_reg <= 1'b1;
      end
      else
      begin
         st_reg <= st_next;
         cnt_reg <= cnt_next;
         bit_reg <= bit_next;
         sh_reg <= sh_next;
         div_reg <= div_next;
         scl_oe_reg <= scl_oe_next;
         sda_oe_reg <= sda_oe_next;
         rx_reg <= rx_next;
         ackin_reg <= ackin_next;
         scl_prev_reg <= scl_f_reg;
      end
   end

   // =====================================================
   // pin drive, open drain: only ever pulls low
   assign o_pins = '0;
   assign o_pins_oe = {scl_oe_reg, sda_oe_reg};
   assign o_port_mode = ~ctrl_reg.iface_enable;
endmodule

// ### rtl/serial_bus_pkg.sv
package serial_bus_pkg;
   // =====================================================
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_TIMER_CTRL = 8'h04;
   localparam logic [7:0] OFS_DATA = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
   // =====================================================
   // field positions and reset values
   localparam int PRESCALE_EXT_POS = 5;
   localparam int EV_DONE_POS = 0;
   localparam int EV_NACK_POS = 1;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [1:0] EV_RESET = 2'h0;
   localparam logic [3:0] BITS_WITH_ACK = 4'h9;
   localparam logic [3:0] BITS_NO_ACK = 4'h8;
   localparam logic [3:0] ACK_BIT_IDX = 4'h8;
   localparam logic [3:0] LAST_DATA_IDX = 4'h7;
   // divisors indexed by {prescale_extend, clock select}
   localparam logic [15:0][8:0] DIV_TABLE = {
      9'd256, 9'd224, 9'd200, 9'd160, 9'd128, 9'd96, 9'd80, 9'd56,
      9'd128, 9'd112, 9'd100, 9'd80, 9'd64, 9'd48, 9'd40, 9'd28};
   // =====================================================
   // control register layout, bit 7 down to bit 0
   typedef struct packed {
      logic iface_enable;
      logic iface_irq_enable;
      logic master_select;
      logic transmit_select;
      logic serial_format;
      logic [2:0] clk_sel;
   } ctrl_s;
   // open-drain pin pair
   typedef struct packed {
      logic scl;
      logic sda;
   } pins_s;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_LOW,
      ST_HIGH
   } xfer_state_e;
endpackage

// ### bench/serial_bus_ctrl_chk.sv
`timescale 1ns/1ps
// ==========
// port checker
module serial_bus_ctrl_chk
(
   input wire logic i_core_clk, // clock
   input wire logic i_resetn, // reset
   input wire logic i_wb_cyc, // cycle
   input wire logic i_wb_stb, // strobe
   input wire logic i_wb_we, // write
   input wire logic [7:0] i_wb_adr, // address
   input wire logic [3:0] i_wb_sel, // lanes
   input wire logic [31:0] i_wb_dat, // data
   input wire logic o_wb_ack, // ack
   input wire serial_bus_pkg::pins_s o_pins_oe, // pulls
   input wire logic o_port_mode, // ports
   input wire logic o_irq // irq
);
   logic [7:0] ctrl_reg, ctrl_next, half_reg, half_next, low_reg, low_next;
   logic ext_reg, ext_next, pend_reg, pend_next, wr;
   // shadow of software writes, taken at the ack edge
   assign wr = i_wb_cyc & i_wb_stb & i_wb_we & o_wb_ack & i_wb_sel[0];
   always_comb
   begin
      ctrl_next = (wr && i_wb_adr == serial_bus_pkg::OFS_CTRL) ? i_wb_dat[7:0] : ctrl_reg;
      ext_next = (wr && i_wb_adr == serial_bus_pkg::OFS_TIMER_CTRL) ?
         i_wb_dat[serial_bus_pkg::PRESCALE_EXT_POS] : ext_reg;
      pend_next = (wr && i_wb_adr == serial_bus_pkg::OFS_DATA) | (pend_reg & ~o_pins_oe.scl);
      // half period frozen at the first low half, later writes wait
      half_next = (pend_reg && o_pins_oe.scl) ?
         serial_bus_pkg::DIV_TABLE[{ext_reg, ctrl_reg[2:0]}][8:1] : half_reg;
      low_next = o_pins_oe.scl ? low_reg + 8'h01 : 8'h00;
   end
   always_ff @(posedge i_core_clk)
   begin
      ctrl_reg <= i_resetn ? ctrl_next : 8'h00;
      ext_reg <= i_resetn & ext_next;
      pend_reg <= i_resetn & pend_next;
      half_reg <= i_resetn ? half_next : 8'h00;
      low_reg <= i_resetn ? low_next : 8'h00;
   end
   // ==========
   // properties
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_resetn);
   a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack held too long");
   a_ack_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
      else $error("request not answered");
   a_ack_cause: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
      else $error("ack without request");
   a_reset_state: assert property ($rose(i_resetn) |-> o_port_mode && !o_irq)
      else $error("bad state after reset");
   a_port_follow: assert property ($stable(ctrl_reg[7]) |-> o_port_mode == !ctrl_reg[7])
      else $error("port mode not from enable");
   a_port_release: assert property (o_port_mode [*2] |-> o_pins_oe == 2'h0)
      else $error("pins pulled while disabled");
   a_irq_gate: assert property (!ctrl_reg[6] && $stable(ctrl_reg[6]) |-> !o_irq)
      else $error("irq not gated");
   a_scl_half: assert property ($fell(o_pins_oe.scl) && !o_port_mode |-> low_reg == half_reg)
      else $error("scl low half wrong length");
   c_byte: cover property ($fell(o_pins_oe.scl) && !o_port_mode);
   c_irq: cover property (o_irq);
   c_write: cover property (wr);
endmodule
bind serial_bus_ctrl serial_bus_ctrl_chk i_chk (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
   .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
   .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_ack(o_wb_ack), .o_pins_oe(o_pins_oe),
   .o_port_mode(o_port_mode), .o_irq(o_irq));

// ### bench/serial_bus_peer.sv
`timescale 1ns/1ps
// ==========
// far-side device: pull-ups, bit capture, optional ack
module serial_bus_peer
(
   input wire logic i_clk, // clock
   input wire logic i_clr, // clear
   input wire logic i_ack_en, // ack byte
   input wire logic i_scl_low, // far master pulls scl
   input wire serial_bus_pkg::pins_s i_oe, // pulls
   output serial_bus_pkg::pins_s o_line, // levels
   output logic [7:0] o_byte, // bits seen
   output logic [3:0] o_cnt // scl pulses
);
   logic scl_q, ack_q;
   // released lines float high; a far master may hold scl low
   assign o_line.scl = !(i_oe.scl || i_scl_low);
   // ack only from the falling scl after the eighth rising scl to the next falling scl, so sda never moves while scl is high
   assign o_line.sda = !(i_oe.sda || ack_q);
   // shift data in on the first eight rising scl edges, msb first
   always @(posedge i_clk)
   begin
      scl_q <= o_line.scl;
      if (i_clr)
      begin
         o_cnt <= 4'h0;
         o_byte <= 8'h00;
         ack_q <= 1'b0;
      end
      else if (o_line.scl && !scl_q)
      begin
         o_cnt <= o_cnt + 4'h1;
         if (o_cnt < 4'h8)
            o_byte <= {o_byte[6:0], o_line.sda};
      end
      else if (!o_line.scl && scl_q)
      begin
         ack_q <= i_ack_en && o_cnt == 4'h8;
      end
   end
endmodule

// ### bench/serial_bus_ctrl_bench.sv
`timescale 1ns/1ps
// ==========
// register and transfer bench
module serial_bus_ctrl_bench;
   logic clk = 1'b0, rstn = 1'b0, stb = 1'b0, we = 1'b0, clr = 1'b1, ack_en = 1'b0;
   logic [7:0] adr = 8'h00, wd = 8'h00, rdat, pbyte, c;
   logic [31:0] rd32;
   logic ack, pm, irq, rhi, far_low = 1'b0;
   logic [3:0] pcnt, k;
   serial_bus_pkg::pins_s line, oe, pout;
   int num_errors = 0, n_compared = 0, n;
   logic [23:0] rows [5] = '{24'h007E7E, 24'h04FF20, 24'h1CFF00, 24'h140303, 24'h000000};
   always #5 clk = ~clk;
   serial_bus_ctrl i_dut (.i_core_clk(clk), .i_resetn(rstn), .i_wb_cyc(stb), .i_wb_stb(stb),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat({24'h000000, wd}),
      .o_wb_dat(rd32), .o_wb_ack(ack), .i_pins(line), .o_pins(pout), .o_pins_oe(oe),
      .o_port_mode(pm), .o_irq(irq));
   serial_bus_peer i_peer (.i_clk(clk), .i_clr(clr), .i_ack_en(ack_en), .i_scl_low(far_low),
      .i_oe(oe),
      .o_line(line), .o_byte(pbyte), .o_cnt(pcnt));
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
      n_compared++;
      if (s !== e)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   // classic cycle, held until ack is sampled
   task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
      int t;
      @(posedge clk);
      adr <= a;
      we <= w;
      wd <= d;
      stb <= 1'b1;
      t = 0;
      do
      begin
         @(posedge clk);
         t++;
      end
      while (ack !== 1'b1 && t < 50);
      // a missing answer is a mismatch, not a silent pass
      if (ack !== 1'b1)
      begin
         num_errors++;
         $display("[ERR] ack expected 1 seen %b", ack);
      end
      rdat = rd32[7:0];
      rhi = |rd32[31:8];
      stb <= 1'b0;
   endtask
   task automatic wait_done();
      n = 0;
      do
      begin
         bus(serial_bus_pkg::OFS_IRQ_STAT, 1'b0, 8'h00);
         n++;
      end
      while (rdat[0] !== 1'b1 && n < 1000);
      chk("done", 8'h01, {7'h00, rdat[0]});
   endtask
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      bus(serial_bus_pkg::OFS_CTRL, 1'b0, 8'h00);
      chk("ctrl", 8'h00, rdat);
      chk("port", 8'h01, 8'(pm));
      $display("reset test done");
      foreach (rows[j])
      begin
         bus(rows[j][23:16], 1'b1, rows[j][15:8]);
         bus(rows[j][23:16], 1'b0, 8'h00);
         chk("reg", rows[j][7:0], rdat);
         chk("upper", 8'h00, {7'h00, rhi});
      end
      $display("register test done");
      // every divisor code, both formats, both directions, master mode only
      // peer takes any rate
      for (int i = 0; i < 16; i++)
      begin
         k = 4'(i);
         c = {3'b101, k[0], k[2], k[2:0]};
         ack_en <= k[1] & ~k[2];
         clr <= 1'b1;
         bus(serial_bus_pkg::OFS_TIMER_CTRL, 1'b1, {2'h0, k[3], 5'h00});
         bus(serial_bus_pkg::OFS_CTRL, 1'b1, c);
         clr <= 1'b0;
         bus(serial_bus_pkg::OFS_DATA, 1'b1, 8'h96);
         bus(serial_bus_pkg::OFS_CTRL, 1'b1, c ^ 8'h07);
         bus(serial_bus_pkg::OFS_STATUS, 1'b0, 8'h00);
         chk("busy", 8'h01, {7'h00, rdat[0]});
         wait_done();
         chk("pulses", k[2] ? 8'h08 : 8'h09, 8'(pcnt));
         chk("byte", k[0] ? 8'h96 : 8'hFF, pbyte);
         chk("nack", 8'(k[0] & ~k[2] & ~k[1]), {7'h00, rdat[1]});
         bus(serial_bus_pkg::OFS_DATA, 1'b0, 8'h00);
         chk("rx", k[0] ? 8'h96 : 8'hFF, rdat);
         bus(serial_bus_pkg::OFS_IRQ_STAT, 1'b1, 8'h03);
      end
      $display("transfer test done");
      // a slave waits for a far master, then disabling frees the pins
      clr <= 1'b1;
      bus(serial_bus_pkg::OFS_CTRL, 1'b1, 8'h90);
      clr <= 1'b0;
      bus(serial_bus_pkg::OFS_DATA, 1'b1, 8'h5A);
      repeat (300) @(posedge clk);
      chk("slave", 8'h00, 8'(pcnt));
      chk("port", 8'h00, 8'(pm));
      // far master clocks nine bits, then holds scl low to end the ack bit
      for (int i = 0; i < 19; i++)
      begin
         far_low <= ~far_low;
         repeat (20) @(posedge clk);
      end
      wait_done();
      chk("slave nack", 8'h01, {7'h00, rdat[1]});
      chk("slave byte", 8'h5A, pbyte);
      chk("slave pulses", 8'h09, 8'(pcnt));
      bus(serial_bus_pkg::OFS_IRQ_STAT, 1'b1, 8'h03);
      bus(serial_bus_pkg::OFS_CTRL, 1'b1, 8'h00);
      far_low <= 1'b0;
      repeat (2) @(negedge clk);
      chk("release", 8'h04, 8'({pm, 2'(oe)}));
      chk("drive", 8'h00, 8'(2'(pout)));
      $display("slave test done");
      bus(serial_bus_pkg::OFS_CTRL, 1'b1, 8'hE8);
      bus(serial_bus_pkg::OFS_DATA, 1'b1, 8'h00);
      n = 0;
      while (irq !== 1'b1 && n < 3000)
      begin
         @(posedge clk);
         n++;
      end
      chk("irq", 8'h01, 8'(irq));
      bus(serial_bus_pkg::OFS_IRQ_MASK, 1'b1, 8'h00);
      @(negedge clk);
      chk("masked", 8'h00, 8'(irq));
      bus(serial_bus_pkg::OFS_IRQ_MASK, 1'b1, 8'h03);
      bus(serial_bus_pkg::OFS_IRQ_STAT, 1'b1, 8'h03);
      bus(serial_bus_pkg::OFS_IRQ_STAT, 1'b0, 8'h00);
      chk("cleared", 8'h00, rdat);
      $display("irq test done");
      // reset in the middle of a master byte
      bus(serial_bus_pkg::OFS_CTRL, 1'b1, 8'hA0);
      bus(serial_bus_pkg::OFS_DATA, 1'b1, 8'h00);
      repeat (100) @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      bus(serial_bus_pkg::OFS_TIMER_CTRL, 1'b0, 8'h00);
      chk("timer reset", 8'h00, rdat);
      bus(serial_bus_pkg::OFS_CTRL, 1'b0, 8'h00);
      chk("ctrl reset", 8'h00, rdat);
      chk("pins reset", 8'h04, 8'({pm, 2'(oe)}));
      $display("reset midway test done");
      complete_run();
   end
   // watchdog well past the longest expected run
   initial
   begin
      repeat (90000) @(posedge clk);
      num_errors++;
      complete_run();
   end
endmodule
